// file: hdl/fuse_signature_config_store.sv
// fuse bytes, working latches, signature space and page address split
// assumes request port and lock bit come from logic on ref_clk_in;
// prog_mode_in is a pin and is synchronised here
`timescale 1ns/1ps
module fuse_signature_config_store #(
	parameter int         VARIANT   = fuse_store_pkg::VAR_LARGE,
	parameter logic [7:0] SIG_BYTE0 = 8'hA5,
	parameter logic [7:0] SIG_BYTE1 = 8'h5A,
	parameter logic [7:0] SIG_BYTE2 = 8'h3C,
	parameter logic [7:0] CAL_BYTE  = 8'h80,
	parameter int         WR_CYC    = fuse_store_pkg::FUSE_WR_CYC,
	parameter int         ER_CYC    = fuse_store_pkg::ERASE_CYC,
	localparam int        PC_W      = fuse_store_pkg::pc_width(VARIANT),
	localparam int        PC_OW     = fuse_store_pkg::pc_off_width(VARIANT),
	localparam int        EE_W      = fuse_store_pkg::ee_width(VARIANT),
	localparam int        EE_OW     = fuse_store_pkg::EE_OW
) (
	// clock and reset
	input  wire logic               ref_clk_in,
	input  wire logic               resetn_in,
	// programming mode pin and path
	input  wire logic               prog_mode_in,
	input  wire logic               prog_serial_in,
	// programmer requests
	input  wire logic               req_valid_in,
	input  wire logic [2:0]         req_cmd_in,
	input  wire logic [1:0]         req_sel_in,
	input  wire logic               req_hi_in,
	input  wire logic [7:0]         req_data_in,
	// lock state, 0 means programmed
	input  wire logic               memory_lock_first_in,
	// oscillator trim writes from software
	input  wire logic               trim_wr_in,
	input  wire logic [7:0]         trim_data_in,
	// request answers
	output logic                    busy_out,
	output logic                    rd_valid_out,
	output logic [7:0]              rd_data_out,
	output logic                    refused_out,
	output logic                    done_out,
	output logic                    erase_flash_out,
	output logic                    erase_eeprom_out,
	// latched configuration, raw fuse polarity; clock_pin_oe_out is inverted, int_rc_8mhz_sel_out is decoded, eeprom_preserve_out follows the live stored bit
	output logic                    self_program_allow_out,
	output logic                    reset_vector_sel_out,
	output logic [1:0]              boot_size_out,
	output logic                    ext_reset_disable_out,
	output logic                    debug_link_enable_out,
	output logic                    serial_prog_allow_out,
	output logic                    watchdog_forced_on_out,
	output logic                    eeprom_preserve_out,
	output logic [2:0]              brownout_level_out,
	output logic                    clock_div_eight_out,
	output logic [1:0]              startup_time_out,
	output logic [3:0]              clock_source_out,
	output logic                    int_rc_8mhz_sel_out,
	output logic                    clock_pin_oe_out,
	// oscillator trim
	output logic [7:0]              rc_osc_trim_out,
	// page address split
	input  wire logic [PC_W-1:0]    flash_pc_in,
	output logic [PC_W-PC_OW-1:0]   page_index_field_out,
	output logic [PC_OW-1:0]        page_word_offset_out,
	input  wire logic [EE_W-1:0]    eeprom_addr_in,
	output logic [EE_W-EE_OW-1:0]   eeprom_page_index_out,
	output logic [EE_OW-1:0]        eeprom_byte_offset_out
);
	import fuse_store_pkg::*;

	localparam logic [7:0] EXT_DEF  = ext_default(VARIANT);
	localparam logic [7:0] EXT_USED = ext_used(VARIANT);
	localparam bit         SMALL    = (VARIANT == VAR_SMALL);

	// stored fuse bytes and working latches
	logic [7:0]  fuse_ext_q;
	logic [7:0]  fuse_hi_q;
	logic [7:0]  fuse_lo_q;
	logic [7:0]  work_ext_q;
	logic [7:0]  work_hi_q;
	logic [7:0]  work_lo_q;
	// mode synchroniser and edges
	logic        mode_s1_q;
	logic        mode_q;
	logic        mode_d1_q;
	logic        pwrup_q;
	logic        relatch;
	// request handling
	prog_state_t state_q;
	logic [15:0] cnt_q;
	logic [1:0]  pend_sel_q;
	logic [7:0]  pend_val_q;
	logic        refuse_d;
	logic        accept;
	logic [7:0]  wr_val_d;
	logic [7:0]  rd_data_d;
	logic        wr_end;
	logic        er_end;
	logic        rd_valid_q;
	logic [7:0]  rd_data_q;
	logic        refused_q;
	logic        done_q;
	logic        erase_flash_q;
	logic        erase_eeprom_q;
	logic [7:0]  trim_q;

	// two flops before the mode pin is used
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			mode_s1_q <= 1'b0;
			mode_q    <= 1'b0;
			mode_d1_q <= 1'b0;
		end else begin
			mode_s1_q <= prog_mode_in;
			mode_q    <= mode_s1_q;
			mode_d1_q <= mode_q;
		end
	end

	// one-cycle marker after reset release, the power-up latch point
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			pwrup_q <= 1'b1;
		end else begin
			pwrup_q <= 1'b0;
		end
	end

	// exit also relatches, so changes made in the session take hold then
	assign relatch = pwrup_q || (mode_q != mode_d1_q);

	// request checks
	always_comb begin
		refuse_d = 1'b0;
		case (req_cmd_in)
			CMD_WR_FUSE: begin
				refuse_d = !memory_lock_first_in || (req_sel_in == 2'h3);
			end
			CMD_RD_FUSE: begin
				refuse_d = (req_sel_in == 2'h3);
			end
			CMD_RD_SIG: begin
				// lock state is not looked at here
				refuse_d = (req_sel_in == 2'h3);
			end
			CMD_ERASE: begin
				refuse_d = 1'b0;
			end
			default: begin
				refuse_d = 1'b1;
			end
		endcase
		if (!mode_q || (state_q != ST_IDLE)) begin
			refuse_d = 1'b1;
		end
		if (prog_serial_in && work_hi_q[HI_SERIAL_PROG_BIT]) begin
			refuse_d = 1'b1;
		end
	end

	assign accept = req_valid_in && !refuse_d;

	// value to be stored by a fuse write
	always_comb begin
		wr_val_d = req_data_in;
		case (req_sel_in)
			SEL_HIGH: begin
				if (prog_serial_in) begin
					wr_val_d[HI_SERIAL_PROG_BIT] = fuse_hi_q[HI_SERIAL_PROG_BIT];
				end
			end
			SEL_EXT: begin
				wr_val_d = req_data_in | ~EXT_USED;
			end
			default: begin
				wr_val_d = req_data_in;
			end
		endcase
	end

	// read mux, raw stored values so 0 shows a programmed bit
	always_comb begin
		rd_data_d = 8'hFF;
		if (req_cmd_in == CMD_RD_FUSE) begin
			case (req_sel_in)
				SEL_LOW:  rd_data_d = fuse_lo_q;
				SEL_HIGH: rd_data_d = fuse_hi_q;
				SEL_EXT:  rd_data_d = fuse_ext_q;
				default:  rd_data_d = 8'hFF;
			endcase
		end else begin
			case (req_sel_in)
				SIG_ADDR0: rd_data_d = req_hi_in ? CAL_BYTE : SIG_BYTE0;
				SIG_ADDR1: rd_data_d = SIG_BYTE1;
				SIG_ADDR2: rd_data_d = SIG_BYTE2;
				default:   rd_data_d = 8'hFF;
			endcase
		end
	end

	assign wr_end = (state_q == ST_WRITE) && (cnt_q == 16'(WR_CYC - 1));
	assign er_end = (state_q == ST_ERASE) && (cnt_q == 16'(ER_CYC - 1));

	// write and erase sequencing
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 16'h0000;
			pend_sel_q <= SEL_LOW;
			pend_val_q <= 8'hFF;
		end else begin
			case (state_q)
				ST_IDLE: begin
					cnt_q <= 16'h0000;
					if (accept && (req_cmd_in == CMD_WR_FUSE)) begin
						state_q    <= ST_WRITE;
						pend_sel_q <= req_sel_in;
						pend_val_q <= wr_val_d;
					end else if (accept && (req_cmd_in == CMD_ERASE)) begin
						state_q <= ST_ERASE;
					end
				end
				ST_WRITE: begin
					cnt_q <= cnt_q + 16'h0001;
					if (wr_end) begin
						state_q <= ST_IDLE;
					end
				end
				ST_ERASE: begin
					cnt_q <= cnt_q + 16'h0001;
					if (er_end) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// stored fuse bytes, fresh part values at power-up
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			fuse_ext_q <= EXT_DEF;
			fuse_hi_q  <= HI_DEF;
			fuse_lo_q  <= LO_DEF;
		end else if (wr_end) begin
			// erase never reaches these bytes
			case (pend_sel_q)
				SEL_LOW:  fuse_lo_q  <= pend_val_q;
				SEL_HIGH: fuse_hi_q  <= pend_val_q;
				SEL_EXT:  fuse_ext_q <= pend_val_q;
				default:  fuse_lo_q  <= fuse_lo_q;
			endcase
		end
	end

	// working latches only follow stored bytes at latch points
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			work_ext_q <= EXT_DEF;
			work_hi_q  <= HI_DEF;
			work_lo_q  <= LO_DEF;
		end else if (relatch) begin
			work_ext_q <= fuse_ext_q;
			work_hi_q  <= fuse_hi_q;
			work_lo_q  <= fuse_lo_q;
		end
	end

	// answers to the programmer
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 8'h00;
			refused_q  <= 1'b0;
		end else begin
			rd_valid_q <= accept && ((req_cmd_in == CMD_RD_FUSE) || (req_cmd_in == CMD_RD_SIG));
			refused_q  <= req_valid_in && refuse_d;
			if (accept) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	// completion and erase strobes
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			done_q         <= 1'b0;
			erase_flash_q  <= 1'b0;
			erase_eeprom_q <= 1'b0;
		end else begin
			done_q         <= wr_end || er_end;
			erase_flash_q  <= er_end;
			// live stored bit, so a preserve set this session counts
			erase_eeprom_q <= er_end && fuse_hi_q[HI_EE_PRESERVE_BIT];
		end
	end

	// trim register reloads the calibration value on every reset
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			trim_q <= CAL_BYTE;
		end else if (trim_wr_in) begin
			trim_q <= trim_data_in;
		end
	end

	assign busy_out         = (state_q != ST_IDLE);
	assign rd_valid_out     = rd_valid_q;
	assign rd_data_out      = rd_data_q;
	assign refused_out      = refused_q;
	assign done_out         = done_q;
	assign erase_flash_out  = erase_flash_q;
	assign erase_eeprom_out = erase_eeprom_q;
	assign rc_osc_trim_out  = trim_q;

	// small variant has only the self-programming bit in the extended byte
	assign self_program_allow_out = SMALL ? work_ext_q[EXT_SELF_PROG_BIT] : 1'b1;
	assign reset_vector_sel_out   = SMALL ? 1'b1 : work_ext_q[EXT_RESET_VEC_BIT];
	assign boot_size_out          = SMALL ? 2'b11 : work_ext_q[EXT_BOOT_LSB +: 2];
	assign ext_reset_disable_out  = work_hi_q[HI_RESET_DIS_BIT];
	assign debug_link_enable_out  = work_hi_q[HI_DEBUG_BIT];
	assign serial_prog_allow_out  = work_hi_q[HI_SERIAL_PROG_BIT];
	assign watchdog_forced_on_out = work_hi_q[HI_WATCHDOG_BIT];
	assign eeprom_preserve_out    = fuse_hi_q[HI_EE_PRESERVE_BIT];
	assign brownout_level_out     = work_hi_q[HI_BROWNOUT_LSB +: 3];
	assign clock_div_eight_out    = work_lo_q[LO_DIV8_BIT];
	assign startup_time_out       = work_lo_q[LO_STARTUP_LSB +: 2];
	assign clock_source_out       = work_lo_q[LO_SOURCE_LSB +: 4];
	assign int_rc_8mhz_sel_out    = (work_lo_q[LO_SOURCE_LSB +: 4] == SRC_RC_8MHZ);
	// pad mux outside routes the system clock while this is high
	assign clock_pin_oe_out       = !work_lo_q[LO_CLK_PIN_BIT];

	// page address split
	page_addr_if #(.AW(PC_W), .OW(PC_OW)) flash_addr ();
	page_addr_if #(.AW(EE_W), .OW(EE_OW)) eeprom_addr ();

	assign flash_addr.addr  = flash_pc_in;
	assign eeprom_addr.addr = eeprom_addr_in;

	page_splitter #(.AW(PC_W), .OW(PC_OW)) flash_split (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.bus        (flash_addr)
	);

	page_splitter #(.AW(EE_W), .OW(EE_OW)) eeprom_split (
		.ref_clk_in (ref_clk_in),
		.resetn_in  (resetn_in),
		.bus        (eeprom_addr)
	);

	assign page_index_field_out   = flash_addr.page_index;
	assign page_word_offset_out   = flash_addr.page_offset;
	assign eeprom_page_index_out  = eeprom_addr.page_index;
	assign eeprom_byte_offset_out = eeprom_addr.page_offset;
endmodule

// file: hdl/fuse_store_pkg.sv
// constants, field layout and defaults of the fuse and signature store
// assumes one 50 MHz clock; figures not given elsewhere are plain defaults
package fuse_store_pkg;
	// device variants
	localparam int VAR_SMALL = 0;
	localparam int VAR_MID   = 1;
	localparam int VAR_LARGE = 2;

	// flash and eeprom address split
	localparam int PC_W_SMALL  = 11;
	localparam int PC_W_MID    = 12;
	localparam int PC_W_LARGE  = 13;
	localparam int PC_OW_SMALL = 5;
	localparam int PC_OW_LARGE = 6;
	localparam int EE_W_SMALL  = 8;
	localparam int EE_W_LARGE  = 9;
	localparam int EE_OW       = 2;

	// extended byte fields
	localparam int EXT_SELF_PROG_BIT = 0;
	localparam int EXT_RESET_VEC_BIT = 0;
	localparam int EXT_BOOT_LSB      = 1;
	localparam logic [7:0] EXT_DEF_SMALL  = 8'hFF;
	localparam logic [7:0] EXT_DEF_LARGE  = 8'hF9;
	localparam logic [7:0] EXT_USED_SMALL = 8'h01;
	localparam logic [7:0] EXT_USED_LARGE = 8'h07;

	// high byte fields
	localparam int HI_RESET_DIS_BIT   = 7;
	localparam int HI_DEBUG_BIT       = 6;
	localparam int HI_SERIAL_PROG_BIT = 5;
	localparam int HI_WATCHDOG_BIT    = 4;
	localparam int HI_EE_PRESERVE_BIT = 3;
	localparam int HI_BROWNOUT_LSB    = 0;
	localparam logic [7:0] HI_DEF     = 8'hDF;

	// low byte fields
	localparam int LO_DIV8_BIT      = 7;
	localparam int LO_CLK_PIN_BIT   = 6;
	localparam int LO_STARTUP_LSB   = 4;
	localparam int LO_SOURCE_LSB    = 0;
	localparam logic [7:0] LO_DEF   = 8'h62;
	localparam logic [3:0] SRC_RC_8MHZ = 4'h2;

	// fuse byte select and signature addresses
	localparam logic [1:0] SEL_LOW  = 2'h0;
	localparam logic [1:0] SEL_HIGH = 2'h1;
	localparam logic [1:0] SEL_EXT  = 2'h2;
	localparam logic [1:0] SIG_ADDR0 = 2'h0;
	localparam logic [1:0] SIG_ADDR1 = 2'h1;
	localparam logic [1:0] SIG_ADDR2 = 2'h2;

	// request commands
	localparam logic [2:0] CMD_WR_FUSE = 3'h1;
	localparam logic [2:0] CMD_RD_FUSE = 3'h2;
	localparam logic [2:0] CMD_RD_SIG  = 3'h3;
	localparam logic [2:0] CMD_ERASE   = 3'h4;

	// timing
	localparam int CLK_NS      = 20;
	localparam int FUSE_WR_NS  = 1000;
	localparam int ERASE_NS    = 2000;
	localparam int FUSE_WR_CYC = (FUSE_WR_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC   = (ERASE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_ERASE} prog_state_t;

	function automatic int pc_width(input int v);
		return (v == VAR_SMALL) ? PC_W_SMALL : (v == VAR_MID) ? PC_W_MID : PC_W_LARGE;
	endfunction

	function automatic int pc_off_width(input int v);
		return (v == VAR_LARGE) ? PC_OW_LARGE : PC_OW_SMALL;
	endfunction

	function automatic int ee_width(input int v);
		return (v == VAR_SMALL) ? EE_W_SMALL : EE_W_LARGE;
	endfunction

	function automatic logic [7:0] ext_default(input int v);
		return (v == VAR_SMALL) ? EXT_DEF_SMALL : EXT_DEF_LARGE;
	endfunction

	function automatic logic [7:0] ext_used(input int v);
		return (v == VAR_SMALL) ? EXT_USED_SMALL : EXT_USED_LARGE;
	endfunction
endpackage

// file: hdl/page_addr_if.sv
// address, page index and in-page offset travelling together
// assumes the user drives addr and the splitter returns the split
`timescale 1ns/1ps
interface page_addr_if #(
	parameter int AW = 13,
	parameter int OW = 6
);
	logic [AW-1:0]    addr;
	logic [AW-OW-1:0] page_index;
	logic [OW-1:0]    page_offset;

	modport split (input addr, output page_index, output page_offset);
	modport user (output addr, input page_index, input page_offset);
endinterface

// file: hdl/page_splitter.sv
// registered split of an address into page index and in-page offset
// assumes addr comes from logic on ref_clk_in
`timescale 1ns/1ps
module page_splitter #(
	parameter int AW = 13,
	parameter int OW = 6
) (
	// clock and reset
	input wire logic    ref_clk_in,
	input wire logic    resetn_in,
	// address in, split out
	page_addr_if.split  bus
);
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			bus.page_index  <= '0;
			bus.page_offset <= '0;
		end else begin
			bus.page_index  <= bus.addr[AW-1:OW];
			bus.page_offset <= bus.addr[OW-1:0];
		end
	end
endmodule

// file: tb/fuse_programmer.sv
// programmer model: one request at a time, waits for its answer
// assumes answers are single-cycle pulses on the shared clock
`timescale 1ns/1ps
module fuse_programmer (
	// clock
	input  wire logic       clk_in,
	// answers
	input  wire logic       rd_valid_in,
	input  wire logic       refused_in,
	input  wire logic       done_in,
	input  wire logic [7:0] rd_data_in,
	// request port
	output logic            req_valid_out,
	output logic [2:0]      req_cmd_out,
	output logic [1:0]      req_sel_out,
	output logic            req_hi_out,
	output logic [7:0]      req_data_out,
	output logic            serial_out,
	output logic            lock_first_out
);
	initial begin
		{req_valid_out, req_cmd_out, req_sel_out, req_hi_out, req_data_out, serial_out} = '0;
		lock_first_out = 1'b1;
	end
	// locking freezes fuses, so the bench locks after its fuse writes, then checks that a locked write is refused
	task automatic set_lock(input logic v);
		@(posedge clk_in) lock_first_out <= v;
	endtask
	task automatic xfer(input logic [2:0] c, input logic [1:0] s, input logic h, input logic [7:0] d,
		input logic sr, output logic [7:0] q, output logic rf);
		int n;
		@(posedge clk_in);
		req_valid_out <= 1'b1;
		req_cmd_out <= c;
		req_sel_out <= s;
		req_hi_out <= h;
		req_data_out <= d;
		serial_out <= sr;
		@(posedge clk_in);
		req_valid_out <= 1'b0;
		req_data_out <= ~d;
		// read and refusal answers stand only for the cycle right after the take
		#1;
		n = 0;
		while (!(rd_valid_in || refused_in || done_in) && n < 400) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		q = rd_data_in;
		rf = refused_in;
	endtask
endmodule

// file: tb/fuse_store_chk.sv
// checker for the fuse and signature store top ports
// assumes one clock, async active-low reset; bound at the foot of this file
`timescale 1ns/1ps
module fuse_store_chk #(
	parameter int         PC_W     = 13,
	parameter int         PC_OW    = 6,
	parameter int         EE_W     = 9,
	parameter logic [7:0] CAL_BYTE = 8'h80
) (
	// clock and reset
	input wire logic                 ref_clk_in,
	input wire logic                 resetn_in,
	// requests
	input wire logic                 prog_mode_in,
	input wire logic                 prog_serial_in,
	input wire logic                 req_valid_in,
	input wire logic [2:0]           req_cmd_in,
	input wire logic [1:0]           req_sel_in,
	input wire logic                 memory_lock_first_in,
	// answers and state
	input wire logic                 busy_out,
	input wire logic                 rd_valid_out,
	input wire logic                 refused_out,
	input wire logic                 done_out,
	input wire logic                 erase_flash_out,
	input wire logic                 erase_eeprom_out,
	input wire logic                 eeprom_preserve_out,
	input wire logic                 serial_prog_allow_out,
	input wire logic                 clock_div_eight_out,
	input wire logic [1:0]           startup_time_out,
	input wire logic [3:0]           clock_source_out,
	input wire logic                 int_rc_8mhz_sel_out,
	input wire logic [7:0]           rc_osc_trim_out,
	// address split
	input wire logic [PC_W-1:0]      flash_pc_in,
	input wire logic [PC_W-PC_OW-1:0] page_index_field_out,
	input wire logic [PC_OW-1:0]     page_word_offset_out,
	input wire logic [EE_W-1:0]      eeprom_addr_in,
	input wire logic [EE_W-3:0]      eeprom_page_index_out,
	input wire logic [1:0]           eeprom_byte_offset_out
);
	import fuse_store_pkg::*;
	// counts edges with the mode pin high; covers the synchroniser delay
	logic [2:0] up_q;
	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			up_q <= 3'h0;
		else if (!prog_mode_in)
			up_q <= 3'h0;
		else if (up_q != 3'h7)
			up_q <= up_q + 3'h1;
	end
	wire take = req_valid_in && (up_q >= 3'h4) && !busy_out;
	wire ser_blk = prog_serial_in && serial_prog_allow_out;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);

	a_lock_refuses: assert property (take && req_cmd_in == CMD_WR_FUSE && !memory_lock_first_in
		|=> refused_out && !busy_out) else $error("locked fuse write not refused");
	a_serial_refused: assert property (take && ser_blk |=> refused_out)
		else $error("serial request not refused");
	a_sig_when_locked: assert property (take && req_cmd_in == CMD_RD_SIG && req_sel_in != 2'h3 && !ser_blk
		|=> rd_valid_out && !refused_out) else $error("signature read not answered");
	a_erase_eeprom_sel: assert property (erase_flash_out |-> erase_eeprom_out == eeprom_preserve_out)
		else $error("eeprom erase does not follow preserve fuse");
	a_eeprom_with_done: assert property (erase_eeprom_out |-> erase_flash_out && done_out)
		else $error("eeprom erase outside chip erase");
	a_rc_source: assert property (int_rc_8mhz_sel_out == (clock_source_out == SRC_RC_8MHZ))
		else $error("rc select does not match clock source");
	a_trim_reset: assert property ($rose(resetn_in) |-> rc_osc_trim_out == CAL_BYTE)
		else $error("trim not loaded on reset");
	a_flash_split: assert property ($past(resetn_in) |->
		{page_index_field_out, page_word_offset_out} == $past(flash_pc_in)) else $error("flash split wrong");
	a_eeprom_split: assert property ($past(resetn_in) |->
		{eeprom_page_index_out, eeprom_byte_offset_out} == $past(eeprom_addr_in)) else $error("eeprom split wrong");
	a_latch_hold: assert property (prog_mode_in [*8] |->
		$stable({clock_div_eight_out, startup_time_out, clock_source_out, serial_prog_allow_out}))
		else $error("latched fuses changed inside programming mode");

	c_eeprom_erase: cover property (erase_eeprom_out);
	c_refusal: cover property (refused_out);
	c_read: cover property (rd_valid_out);
endmodule
bind fuse_signature_config_store fuse_store_chk #(.PC_W(PC_W), .PC_OW(PC_OW), .EE_W(EE_W), .CAL_BYTE(CAL_BYTE))
	fuse_store_chk_inst (.ref_clk_in, .resetn_in, .prog_mode_in, .prog_serial_in, .req_valid_in, .req_cmd_in,
	.req_sel_in, .memory_lock_first_in, .busy_out, .rd_valid_out, .refused_out, .done_out, .erase_flash_out,
	.erase_eeprom_out, .eeprom_preserve_out, .serial_prog_allow_out, .clock_div_eight_out, .startup_time_out,
	.clock_source_out, .int_rc_8mhz_sel_out, .rc_osc_trim_out, .flash_pc_in, .page_index_field_out,
	.page_word_offset_out, .eeprom_addr_in, .eeprom_page_index_out, .eeprom_byte_offset_out);

// file: tb/tb_fuse_signature_config_store.sv
// self-checking bench for the fuse and signature store, large variant
// assumes short write and erase counts; programmer model drives requests
`timescale 1ns/1ps
module tb_fuse_signature_config_store;
	import fuse_store_pkg::*;
	localparam logic [7:0] DEF [3] = '{8'h62, 8'hDF, 8'hF9};
	localparam logic [7:0] SIG [4] = '{8'hA5, 8'h5A, 8'h3C, 8'h80};
	logic        ref_clk_in, resetn_in, prog_mode_in, trim_wr_in, vld, hi, ser, lock, busy, rdv, rfo, done;
	logic        erf, ere, rvs, erd, dbg, spa, wdf, eep, cdv, rc8, cpo, r;
	logic [7:0]  trim_data_in, rdd, trim_q, q, d, d2, dat;
	logic [12:0] flash_pc_in;
	logic [8:0]  eeprom_addr_in;
	logic [2:0]  cmd, bro;
	logic [1:0]  sel, bsz, sut, ebo;
	logic [3:0]  csrc;
	logic [6:0]  pidx, eidx;
	logic [5:0]  pwo;
	int          bad_count, num_checks, i;
	integer      seed = 32'hd8548d17;
	wire [7:0] lat_ext = {5'h1F, bsz, rvs};
	wire [7:0] lat_hi = {erd, dbg, spa, wdf, eep, bro};
	wire [7:0] lat_lo = {cdv, ~cpo, sut, csrc};

	fuse_signature_config_store #(.WR_CYC(2), .ER_CYC(3)) fuse_signature_config_store_inst (
		.ref_clk_in, .resetn_in, .prog_mode_in, .prog_serial_in(ser), .req_valid_in(vld), .req_cmd_in(cmd),
		.req_sel_in(sel), .req_hi_in(hi), .req_data_in(dat), .memory_lock_first_in(lock), .trim_wr_in,
		.trim_data_in, .busy_out(busy), .rd_valid_out(rdv), .rd_data_out(rdd), .refused_out(rfo),
		.done_out(done), .erase_flash_out(erf), .erase_eeprom_out(ere), .self_program_allow_out(),
		.reset_vector_sel_out(rvs), .boot_size_out(bsz), .ext_reset_disable_out(erd),
		.debug_link_enable_out(dbg), .serial_prog_allow_out(spa), .watchdog_forced_on_out(wdf),
		.eeprom_preserve_out(eep), .brownout_level_out(bro), .clock_div_eight_out(cdv),
		.startup_time_out(sut), .clock_source_out(csrc), .int_rc_8mhz_sel_out(rc8), .clock_pin_oe_out(cpo),
		.rc_osc_trim_out(trim_q), .flash_pc_in, .page_index_field_out(pidx), .page_word_offset_out(pwo),
		.eeprom_addr_in, .eeprom_page_index_out(eidx), .eeprom_byte_offset_out(ebo));
	fuse_programmer fuse_programmer_inst (.clk_in(ref_clk_in), .rd_valid_in(rdv), .refused_in(rfo),
		.done_in(done), .rd_data_in(rdd), .req_valid_out(vld), .req_cmd_out(cmd), .req_sel_out(sel),
		.req_hi_out(hi), .req_data_out(dat), .serial_out(ser), .lock_first_out(lock));

	always #10 ref_clk_in = ~ref_clk_in;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic rq(input logic [2:0] c, input logic [1:0] s, input logic h, input logic [7:0] dd, input logic sr);
		fuse_programmer_inst.xfer(c, s, h, dd, sr, q, r);
	endtask
	// serial path keeps its own enable bit
	function automatic logic [7:0] exp_hi_ser(input logic [7:0] old, input logic [7:0] dd);
		return {dd[7:6], old[5], dd[4:0]};
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#1000000;
		bad_count++;
		results;
	end

	initial begin
		{ref_clk_in, resetn_in, trim_wr_in, trim_data_in, flash_pc_in, eeprom_addr_in} = '0;
		prog_mode_in = 1'b1;
		bad_count = 0;
		num_checks = 0;
		repeat (16) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		cyc(8);
		chk(lat_ext, 8'hF9);
		chk(lat_hi, 8'hDF);
		chk(lat_lo, 8'h62);
		chk({7'h0, rc8}, 8'h01);
		chk({7'h0, cpo}, 8'h00);
		chk(trim_q, 8'h80);
		$display("test defaults done");
		for (i = 0; i < 3; i++) begin
			rq(CMD_RD_FUSE, 2'(i), 1'b0, 8'h00, 1'b0);
			chk(q, DEF[i]);
		end
		for (i = 0; i < 4; i++) begin
			rq(CMD_RD_SIG, (i == 3) ? SIG_ADDR0 : 2'(i), i == 3, 8'h00, 1'b0);
			chk(q, SIG[i]);
		end
		rq(CMD_RD_SIG, 2'h3, 1'b0, 8'h00, 1'b0);
		chk({7'h0, r}, 8'h01);
		$display("test reads done");
		d = 8'($random(seed));
		rq(CMD_WR_FUSE, SEL_LOW, 1'b0, d, 1'b0);
		rq(CMD_RD_FUSE, SEL_LOW, 1'b0, 8'h00, 1'b0);
		chk(q, d);
		chk(lat_lo, 8'h62);
		rq(CMD_WR_FUSE, SEL_EXT, 1'b0, 8'h00, 1'b0);
		rq(CMD_RD_FUSE, SEL_EXT, 1'b0, 8'h00, 1'b0);
		chk(q, 8'hF8);
		d2 = 8'($random(seed)) & 8'hD7;
		rq(CMD_WR_FUSE, SEL_HIGH, 1'b0, d2, 1'b0);
		chk({7'h0, eep}, 8'h00);
		rq(CMD_ERASE, 2'h0, 1'b0, 8'h00, 1'b0);
		chk({6'h0, ere, erf}, 8'h01);
		rq(CMD_RD_FUSE, SEL_LOW, 1'b0, 8'h00, 1'b0);
		chk(q, d);
		@(posedge ref_clk_in) prog_mode_in <= 1'b0;
		cyc(8);
		chk(lat_lo, d);
		chk(lat_ext, 8'hF8);
		@(posedge ref_clk_in) prog_mode_in <= 1'b1;
		cyc(8);
		$display("test writes done");
		rq(CMD_WR_FUSE, SEL_HIGH, 1'b0, 8'hFF, 1'b1);
		rq(CMD_RD_FUSE, SEL_HIGH, 1'b0, 8'h00, 1'b1);
		chk(q, exp_hi_ser(d2, 8'hFF));
		rq(CMD_ERASE, 2'h0, 1'b0, 8'h00, 1'b0);
		chk({6'h0, ere, erf}, 8'h03);
		fuse_programmer_inst.set_lock(1'b0);
		rq(CMD_WR_FUSE, SEL_LOW, 1'b0, 8'h00, 1'b0);
		chk({7'h0, r}, 8'h01);
		rq(CMD_RD_FUSE, SEL_LOW, 1'b0, 8'h00, 1'b0);
		chk(q, d);
		rq(CMD_RD_SIG, SIG_ADDR1, 1'b0, 8'h00, 1'b1);
		chk(q, 8'h5A);
		fuse_programmer_inst.set_lock(1'b1);
		rq(CMD_WR_FUSE, SEL_HIGH, 1'b0, 8'hFF, 1'b0);
		@(posedge ref_clk_in) prog_mode_in <= 1'b0;
		cyc(8);
		@(posedge ref_clk_in) prog_mode_in <= 1'b1;
		cyc(8);
		rq(CMD_RD_SIG, SIG_ADDR1, 1'b0, 8'h00, 1'b1);
		chk({7'h0, r}, 8'h01);
		$display("test lock done");
		for (i = 0; i < 16; i++) begin
			@(posedge ref_clk_in) begin
				flash_pc_in <= (i == 0) ? 13'h1FFF : 13'($random(seed));
				eeprom_addr_in <= (i == 0) ? 9'h1FF : 9'($random(seed));
			end
			cyc(1);
			chk({2'h0, pwo}, {2'h0, flash_pc_in[5:0]});
			chk({1'h0, pidx}, {1'h0, flash_pc_in[12:6]});
			chk({6'h0, ebo}, {6'h0, eeprom_addr_in[1:0]});
			chk({1'h0, eidx}, {1'h0, eeprom_addr_in[8:2]});
		end
		$display("test split done");
		@(posedge ref_clk_in) begin
			trim_wr_in <= 1'b1;
			trim_data_in <= d;
		end
		@(posedge ref_clk_in) trim_wr_in <= 1'b0;
		cyc(1);
		chk(trim_q, d);
		@(posedge ref_clk_in) resetn_in <= 1'b0;
		cyc(2);
		@(posedge ref_clk_in) resetn_in <= 1'b1;
		cyc(8);
		chk(trim_q, 8'h80);
		chk(lat_lo, 8'h62);
		chk(lat_hi, 8'hDF);
		$display("test reset done");
		results;
	end
endmodule
